// [common/pcsr_pkg.sv]
// Package for the configuration status register bank: offsets, fields, reset values.
// Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
package pcsr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_REVISION = 8'h04;
    localparam logic [7:0] OFF_COMMAND = 8'h08;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h0C;
    localparam logic [7:0] OFF_EVT_MASK = 8'h10;
    // Status field positions
    localparam int BIT_PAR_DET = 15;
    localparam int BIT_SYS_SIG = 14;
    localparam int BIT_MABT_RCV = 13;
    localparam int BIT_TABT_RCV = 12;
    localparam int BIT_TABT_SIG = 11;
    localparam int BIT_SEL_HI = 10;
    localparam int BIT_SEL_LO = 9;
    localparam int BIT_MDPAR = 8;
    localparam int BIT_B2B_CAP = 7;
    localparam int BIT_HS_CAP = 5;
    localparam int BIT_CAPLIST = 4;
    localparam int BIT_INT_STAT = 3;
    // Command field positions
    localparam int BIT_INTERRUPT_PIN_DISABLE = 10;
    localparam int BIT_SYSTEM_ERROR_PIN_ENABLE = 8;
    localparam int BIT_PAR_RESP = 6;
    // Hardwired values and masks
    localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
    localparam logic [15:0] STATUS_W1C_MASK = 16'hF100;
    localparam logic [15:0] COMMAND_WR_MASK = 16'h0540;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [4:0] EVT_RESET = 5'h00;
    // Event bit positions in event status/mask
    localparam int EVT_PAR = 0;
    localparam int EVT_SYS = 1;
    localparam int EVT_MABT = 2;
    localparam int EVT_TABT = 3;
    localparam int EVT_MDPAR = 4;
    localparam int EVT_N = 5;
endpackage

// [hdl/pcsr_top.sv]
// Configuration status and revision identification register bank with pin drivers.
// Assumes error event inputs are pulses on I_CLK from bus logic; pins are registered.
//
// Overview of operation
// - Any detected parity error sets the parity detected flag, bit 15.
// - Driving a system error onto its pin sets flag bit 14.
// - Own master transaction ending in master abort sets flag bit 13.
// - Target abort received while bus master sets flag bit 12.
// - Target abort signaled, bit 11, always reads zero.
// - Select decode timing bits 10 to 9 read fixed medium code 01.
// - Bit 8 sets on parity pin event while master with response enabled.
// - Back-to-back capable bit 7 reads zero; no fast back-to-back.
// - Bit 5 reports high speed timing capability, read-only.
// - Bit 4 reports a capability list is present, read-only.
// - Bit 3 follows the live interrupt condition from back end.
// - Interrupt A pin driven low while pending and not disabled.
// - Pin disable gates only the pin, never the pending status bit.
// - Read-only 8-bit revision identifier in bits 7 to 0.
// - Without parity response, flag still sets but parity pin stays idle.
// - With pin disable set, interrupt never reaches interrupt A pin.
// - Without system error pin enable, system errors stay off the pin.
`timescale 1ns/1ps
module pcsr_top #(
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h5A, // Arbitrary neutral value
    parameter bit HIGH_SPEED_CAPABLE = 1'b0,
    parameter bit CAPABILITY_LIST_PRESENT = 1'b0
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_PARITY_ERROR,
    input wire logic I_PARITY_PIN_SEEN,
    input wire logic I_IS_MASTER,
    input wire logic I_SYSTEM_ERROR,
    input wire logic I_MASTER_ABORT,
    input wire logic I_TARGET_ABORT,
    input wire logic I_BACKEND_INT,
    output logic O_PARITY_ERROR_PIN_N,
    output logic O_PARITY_ERROR_PIN_OE,
    output logic O_SYSTEM_ERROR_PIN_N,
    output logic O_SYSTEM_ERROR_PIN_OE,
    output logic O_INTERRUPT_A_PIN_N,
    output logic O_INTERRUPT_A_PIN_OE,
    output logic [1:0] O_SELECT_DECODE_TIMING,
    output logic O_BACK_TO_BACK_ENABLE,
    output logic O_IRQ
);
    logic [3:0] flags_q;
    logic mdpar_q;
    logic int_stat_q;
    logic [15:0] command_q;
    logic [4:0] evt_q;
    logic [4:0] mask_q;
    logic ack_q;
    logic req;
    logic wr_acc;
    logic rd_acc;
    logic [15:0] wdata16;
    logic [15:0] status_word;
    logic par_resp;
    logic system_error_pin_enable;
    logic interrupt_pin_disable;
    logic sys_pin_evt;
    logic mdpar_evt;
    logic [4:0] evt_in;
    logic [31:0] rdata_d;

    assign req = (I_AVS_READ || I_AVS_WRITE) && !ack_q;
    assign wr_acc = I_CE && I_AVS_WRITE && !ack_q;
    assign rd_acc = I_CE && I_AVS_READ && !ack_q;
    assign wdata16 = {I_AVS_BYTEENABLE[1] ? I_AVS_WRITEDATA[15:8] : 8'h00,
                      I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : 8'h00};
    assign par_resp = command_q[pcsr_pkg::BIT_PAR_RESP];
    assign system_error_pin_enable = command_q[pcsr_pkg::BIT_SYSTEM_ERROR_PIN_ENABLE];
    assign interrupt_pin_disable = command_q[pcsr_pkg::BIT_INTERRUPT_PIN_DISABLE];
    assign sys_pin_evt = I_SYSTEM_ERROR && system_error_pin_enable;
    assign mdpar_evt = I_PARITY_PIN_SEEN && I_IS_MASTER && par_resp;
    assign evt_in = {mdpar_evt, I_TARGET_ABORT, I_MASTER_ABORT, sys_pin_evt, I_PARITY_ERROR};

    // Status word assembly, reserved bits zero
    always_comb begin
        status_word = 16'h0000;
        status_word[pcsr_pkg::BIT_PAR_DET] = flags_q[3];
        status_word[pcsr_pkg::BIT_SYS_SIG] = flags_q[2];
        status_word[pcsr_pkg::BIT_MABT_RCV] = flags_q[1];
        status_word[pcsr_pkg::BIT_TABT_RCV] = flags_q[0];
        status_word[pcsr_pkg::BIT_TABT_SIG] = 1'b0;
        status_word[pcsr_pkg::BIT_SEL_HI:pcsr_pkg::BIT_SEL_LO] =
            pcsr_pkg::SEL_TIMING_MEDIUM;
        status_word[pcsr_pkg::BIT_MDPAR] = mdpar_q;
        status_word[pcsr_pkg::BIT_B2B_CAP] = 1'b0;
        status_word[pcsr_pkg::BIT_HS_CAP] = HIGH_SPEED_CAPABLE;
        status_word[pcsr_pkg::BIT_CAPLIST] = CAPABILITY_LIST_PRESENT;
        status_word[pcsr_pkg::BIT_INT_STAT] = int_stat_q;
    end

    // Read data mux, unmapped reads zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (I_AVS_ADDRESS)
            pcsr_pkg::OFF_STATUS: rdata_d = {16'h0000, status_word};
            pcsr_pkg::OFF_REVISION: rdata_d = {24'h00_0000, REVISION_IDENTIFIER};
            pcsr_pkg::OFF_COMMAND: rdata_d = {16'h0000, command_q};
            pcsr_pkg::OFF_EVT_STATUS: rdata_d = {27'h000_0000, evt_q};
            pcsr_pkg::OFF_EVT_MASK: rdata_d = {27'h000_0000, mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait cycle, then acknowledge
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ack_q <= 1'b0;
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
        end else if (I_CE) begin
            ack_q <= req;
            O_AVS_WAITREQUEST <= !req;
            if (rd_acc) begin
                O_AVS_READDATA <= rdata_d;
            end
        end
    end

    // Error flags: set wins over write-one-to-clear
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            flags_q <= 4'h0;
            mdpar_q <= 1'b0;
        end else if (I_CE) begin
            if (wr_acc && I_AVS_ADDRESS == pcsr_pkg::OFF_STATUS) begin
                flags_q <= flags_q & ~wdata16[15:12];
                mdpar_q <= mdpar_q & ~wdata16[pcsr_pkg::BIT_MDPAR];
            end
            if (I_PARITY_ERROR) begin
                flags_q[3] <= 1'b1;
            end
            if (sys_pin_evt) begin
                flags_q[2] <= 1'b1;
            end
            if (I_MASTER_ABORT) begin
                flags_q[1] <= 1'b1;
            end
            if (I_TARGET_ABORT && I_IS_MASTER) begin
                flags_q[0] <= 1'b1;
            end
            if (mdpar_evt) begin
                mdpar_q <= 1'b1;
            end
        end
    end

    // Command control bits; only writable fields stored
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            command_q <= pcsr_pkg::COMMAND_RESET;
        end else if (I_CE && wr_acc && I_AVS_ADDRESS == pcsr_pkg::OFF_COMMAND) begin
            command_q <= (command_q & ~(pcsr_pkg::COMMAND_WR_MASK & {{8{I_AVS_BYTEENABLE[1]}},
                {8{I_AVS_BYTEENABLE[0]}}})) | (wdata16 & pcsr_pkg::COMMAND_WR_MASK);
        end
    end

    // Live interrupt status from back end
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            int_stat_q <= 1'b0;
        end else if (I_CE) begin
            int_stat_q <= I_BACKEND_INT;
        end
    end

    // Sticky event status and mask for local interrupt
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            evt_q <= pcsr_pkg::EVT_RESET;
            mask_q <= pcsr_pkg::EVT_RESET;
        end else if (I_CE) begin
            evt_q <= (evt_q & ~((wr_acc && I_AVS_ADDRESS == pcsr_pkg::OFF_EVT_STATUS) ?
                wdata16[4:0] : 5'h00)) | evt_in;
            if (wr_acc && I_AVS_ADDRESS == pcsr_pkg::OFF_EVT_MASK) begin
                mask_q <= wdata16[4:0];
            end
        end
    end

    // Registered pin drivers and interrupt output
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PARITY_ERROR_PIN_N <= 1'b1;
            O_PARITY_ERROR_PIN_OE <= 1'b0;
            O_SYSTEM_ERROR_PIN_N <= 1'b1;
            O_SYSTEM_ERROR_PIN_OE <= 1'b0;
            O_INTERRUPT_A_PIN_N <= 1'b1;
            O_INTERRUPT_A_PIN_OE <= 1'b0;
            O_SELECT_DECODE_TIMING <= pcsr_pkg::SEL_TIMING_MEDIUM;
            O_BACK_TO_BACK_ENABLE <= 1'b0;
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_PARITY_ERROR_PIN_N <= !(I_PARITY_ERROR && par_resp);
            O_PARITY_ERROR_PIN_OE <= I_PARITY_ERROR && par_resp;
            O_SYSTEM_ERROR_PIN_N <= !sys_pin_evt;
            O_SYSTEM_ERROR_PIN_OE <= sys_pin_evt;
            O_INTERRUPT_A_PIN_N <= !(I_BACKEND_INT && !interrupt_pin_disable);
            O_INTERRUPT_A_PIN_OE <= I_BACKEND_INT && !interrupt_pin_disable;
            O_SELECT_DECODE_TIMING <= pcsr_pkg::SEL_TIMING_MEDIUM;
            O_BACK_TO_BACK_ENABLE <= 1'b0;
            O_IRQ <= |((evt_q | evt_in) & mask_q);
        end
    end
endmodule

// [tb/pcsr_asserts.sv]
// Checker for the status register bank: bus answer timing, fixed fields, pins.
// Assumes it is bound to pcsr_top with I_CE held high.
`timescale 1ns/1ps
module pcsr_asserts #(
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h00
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_PARITY_ERROR,
    input wire logic I_SYSTEM_ERROR,
    input wire logic I_BACKEND_INT,
    input wire logic O_PARITY_ERROR_PIN_N,
    input wire logic O_SYSTEM_ERROR_PIN_N,
    input wire logic O_INTERRUPT_A_PIN_N,
    input wire logic [1:0] O_SELECT_DECODE_TIMING,
    input wire logic O_BACK_TO_BACK_ENABLE
);
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);
    sequence taken_s;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    endsequence
    sequence rd_s(logic [7:0] a);
        I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS == a;
    endsequence
    answer_next_a: assert property (taken_s |=> !O_AVS_WAITREQUEST) else $error("late answer");
    answer_once_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("long ack");
    rev_value_a: assert property (rd_s(8'h04) |=> O_AVS_READDATA == {24'h0, REVISION_IDENTIFIER})
        else $error("bad revision");
    status_fixed_a: assert property (rd_s(8'h00) |=> O_AVS_READDATA[11:9] == 3'b001 &&
        O_AVS_READDATA[7:6] == 2'b00 && O_AVS_READDATA[2:0] == 3'b000) else $error("bad fixed");
    timing_fixed_a: assert property (O_SELECT_DECODE_TIMING == 2'b01) else $error("timing");
    no_fast_a: assert property (!O_BACK_TO_BACK_ENABLE) else $error("fast b2b");
    par_pin_a: assert property (!O_PARITY_ERROR_PIN_N |-> $past(I_PARITY_ERROR))
        else $error("stray parity pin");
    sys_pin_a: assert property (!O_SYSTEM_ERROR_PIN_N |-> $past(I_SYSTEM_ERROR))
        else $error("stray system pin");
    int_pin_a: assert property (!O_INTERRUPT_A_PIN_N |-> $past(I_BACKEND_INT))
        else $error("stray int pin");
endmodule
bind pcsr_top pcsr_asserts #(.REVISION_IDENTIFIER(REVISION_IDENTIFIER)) u_chk (.*);

// [tb/pcsr_bus_side.sv]
// Model of the bus logic beside the bank: one-cycle error events and levels.
// Assumes the bench clock; levels are set by the bench directly.
`timescale 1ns/1ps
module pcsr_bus_side (
    input wire logic i_clk,
    output logic [4:0] o_ev,
    output logic o_master,
    output logic o_int
);
    initial begin
        o_ev = 5'h00;
        o_master = 1'b0;
        o_int = 1'b0;
    end
    // Bits: parity, pin seen, system, master abort, target abort
    task automatic fire(input logic [4:0] v);
        @(posedge i_clk);
        o_ev <= v;
        @(posedge i_clk);
        o_ev <= 5'h00;
    endtask
endmodule

// [tb/test_pci_config_status_register.sv]
// Self-checking bench for the status register bank.
// Assumes the checker binds itself and the bus side model supplies events.
`timescale 1ns/1ps
module test_pci_config_status_register;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] q, got;
    logic wreq, irq, int_n, mst, bint;
    logic par_n, sys_n, int_oe;
    logic ce = 1'b1;
    logic [4:0] ev;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    pcsr_bus_side host (.i_clk(clk), .o_ev(ev), .o_master(mst), .o_int(bint));
    pcsr_top dut (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(q), .O_AVS_WAITREQUEST(wreq), .I_PARITY_ERROR(ev[0]),
        .I_PARITY_PIN_SEEN(ev[1]), .I_IS_MASTER(mst), .I_SYSTEM_ERROR(ev[2]),
        .I_MASTER_ABORT(ev[3]), .I_TARGET_ABORT(ev[4]), .I_BACKEND_INT(bint),
        .O_PARITY_ERROR_PIN_N(par_n), .O_PARITY_ERROR_PIN_OE(), .O_SYSTEM_ERROR_PIN_N(sys_n),
        .O_SYSTEM_ERROR_PIN_OE(), .O_INTERRUPT_A_PIN_N(int_n), .O_INTERRUPT_A_PIN_OE(int_oe),
        .O_SELECT_DECODE_TIMING(), .O_BACK_TO_BACK_ENABLE(), .O_IRQ(irq));
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is seen low, then released
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0, d};
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        got = q;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0);
        chk(got, e);
    endtask
    task automatic t_reset;
        rchk(8'h00, 32'h0200);
        rchk(8'h04, 32'h5A);
        rchk(8'h20, 32'h0);
        rchk(8'h0C, 32'h0);
    endtask
    task automatic t_parity;
        host.fire(5'h01);
        #1;
        chk(par_n, 1'b1);
        rchk(8'h00, 32'h8200);
        bus(1'b1, 8'h00, 16'h8000);
        rchk(8'h00, 32'h0200);
        bus(1'b1, 8'h08, 16'h0040);
        host.fire(5'h02);
        rchk(8'h00, 32'h0200);
        host.o_master <= 1'b1;
        host.fire(5'h03);
        #1;
        chk(par_n, 1'b0);
        rchk(8'h00, 32'h8300);
        bus(1'b1, 8'h00, 16'h8100);
        rchk(8'h00, 32'h0200);
    endtask
    task automatic t_system;
        host.fire(5'h04);
        #1;
        chk(sys_n, 1'b1);
        rchk(8'h00, 32'h0200);
        bus(1'b1, 8'h08, 16'h0100);
        host.fire(5'h04);
        #1;
        chk(sys_n, 1'b0);
        rchk(8'h00, 32'h4200);
    endtask
    task automatic t_abort;
        bus(1'b1, 8'h00, 16'hF100);
        bus(1'b1, 8'h0C, 16'h001F);
        bus(1'b1, 8'h10, 16'h0004);
        host.o_master <= 1'b0;
        host.fire(5'h10);
        rchk(8'h00, 32'h0200);
        chk(irq, 1'b0);
        host.o_master <= 1'b1;
        host.fire(5'h18);
        rchk(8'h00, 32'h3200);
        chk(irq, 1'b1);
        bus(1'b1, 8'h00, 16'h0000);
        rchk(8'h00, 32'h3200);
        bus(1'b1, 8'h0C, 16'h0004);
        bus(1'b0, 8'h0C, 16'h0);
        chk(got & 32'h4, 32'h0);
        chk(irq, 1'b0);
    endtask
    task automatic t_int;
        bus(1'b1, 8'h08, 16'hFFFF);
        rchk(8'h08, 32'h0540);
        bus(1'b1, 8'h08, 16'h0000);
        host.o_int <= 1'b1;
        rchk(8'h00, 32'h3208);
        chk(int_n, 1'b0);
        chk(int_oe, 1'b1);
        bus(1'b1, 8'h08, 16'h0400);
        rchk(8'h00, 32'h3208);
        chk(int_n, 1'b1);
        chk(int_oe, 1'b0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_parity;
        t_system;
        t_abort;
        t_int;
        close_out;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            close_out;
        end
    end
endmodule
